// *** rtl/spc_params.svh ***
// Constants for the serializer pin configuration block
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
`define SPC_CLK_PERIOD_NS 8
`define SPC_MIRROR_LIMIT_US 350
`define SPC_MIRROR_LIMIT_CYC ((`SPC_MIRROR_LIMIT_US * 1000) / `SPC_CLK_PERIOD_NS)
`define SPC_MIRROR_DELAY_CYC 2
`define SPC_BITS_PER_PCLK_NARROW 6'h1E
`define SPC_BITS_PER_PCLK_WIDE 6'h28
`define SPC_LATENCY_SS_BITS 13'h1AE0
`define SPC_LATENCY_NOSS_BITS 13'h0BE0
`define SPC_LATCH_NARROW 5'h16
`define SPC_LATCH_WIDE 5'h1E
`define SPC_SHARED_GPIO_W 4
`define SPC_CORRECT_ON 2'h2
`define SPC_CORRECT_OFF 2'h0
`define SPC_STARTUP_CYC 4'h4
`endif

// *** rtl/spc_pin_config.sv ***
// Strap and control pin decoder for the serializer
// Operation
// - Output mirrors remote deserializer general input
// - Output low after power-up and power-down
// - Power-down input low stops all activity; cfg0_level, cfg1_level and latency_limit_bits still track their pins
// - Enable pin selects control-channel or strap functions
// - Enable high: bus-width pin is open-drain port
// - Bus-width strap selects 22 or 30-bit latch
// - Enable high: mode pin picks base/bypass
// - Sync strap enables sync encoding on top pins
// - Pins fourteen/fifteen are data until encoding
// - Pins ten-thirteen are data until programmed
// - Config inputs decode low, high or mid
// - Thirty or forty bit times per pixel clock
// - Latency limit 6880 or 3040 bit times
// - Remote input reaches output within 350 us
// - Pixel clock latches data, references PLL; no pixel clock or PLL here, pins sampled on sys_clk
// - Double strap selects double or single input
// - Correction strap enables error detection/correction
// - Straps captured at startup as power-up values
`timescale 1ns/100ps
`include "spc_params.svh"
module spc_pin_config
  import spc_pkg::*;
#(
  parameter int MIRROR_LIMIT_CYC = `SPC_MIRROR_LIMIT_CYC,
  parameter int GPIO_W = `SPC_SHARED_GPIO_W
)(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic power_down_n,
  input wire logic local_ctrl_chan_pin_en,
  input wire logic bus_width_strap_i,
  output logic bus_width_strap_o,
  output logic bus_width_strap_oe_n,
  input wire logic ctrl_mode_select,
  input wire logic double_input_strap,
  input wire logic error_correct_strap,
  input wire logic tri_level_cfg_0_hi,
  input wire logic tri_level_cfg_0_lo,
  input wire logic tri_level_cfg_1_hi,
  input wire logic tri_level_cfg_1_lo,
  input wire logic remote_general_input,
  input wire logic general_port_1_out,
  input wire logic [GPIO_W-1:0] shared_gpio_en,
  input wire logic [GPIO_W-1:0] shared_gpio_out,
  input wire logic spread_spectrum_en,
  output logic [GPIO_W-1:0] shared_data_port_oe_n,
  output logic remote_mirror_output,
  output logic powered_down,
  output logic ctrl_chan_active,
  output logic bypass_mode,
  output logic strap_bus_wide,
  output logic [4:0] input_latch_width,
  output logic double_input_mode,
  output logic [1:0] error_correct_mode,
  output logic sync_encode_en,
  output logic pins_14_15_are_sync,
  output logic [5:0] bit_times_per_pclk,
  output logic [12:0] latency_limit_bits,
  output spc_level_e cfg0_level,
  output spc_level_e cfg1_level,
  output logic config_valid
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] syn;
  assign raw_pins = {power_down_n, local_ctrl_chan_pin_en, bus_width_strap_i, ctrl_mode_select,
                     double_input_strap, error_correct_strap, tri_level_cfg_0_hi, tri_level_cfg_0_lo,
                     tri_level_cfg_1_hi, tri_level_cfg_1_lo, remote_general_input};
  // Every asynchronous pin crosses two flops first
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    spc_sync_if sif ();
    spc_sync u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .pin(raw_pins[i]),
      .out(sif.src)
    );
    assign syn[i] = sif.level;
  end
  wire pd_n_s = syn[10];
  wire lcc_s = syn[9];
  wire width_s = syn[8];
  wire mode_s = syn[7];
  wire double_s = syn[6];
  wire correct_s = syn[5];
  wire c0h_s = syn[4];
  wire c0l_s = syn[3];
  wire c1h_s = syn[2];
  wire c1l_s = syn[1];
  wire mirror_in_s = syn[0];

  // ************************************************************
  // Power state and startup capture
  // ************************************************************
  spc_state_e state_q;
  spc_state_e state_d;
  logic [3:0] settle_q;
  logic capture;
  logic lcc_q;
  logic width_q;
  logic double_q;
  logic correct_q;
  logic sync_enc_q;
  logic mirror_q;
  logic [$clog2(MIRROR_LIMIT_CYC+1)-1:0] mirror_cnt_q;

  // Down whenever the power-down pin is low; straps settle before capture
  always_comb begin
    state_d = state_q;
    case (state_q)
      SPC_ST_DOWN: if (pd_n_s) state_d = SPC_ST_SETTLE;
      SPC_ST_SETTLE: if (settle_q == `SPC_STARTUP_CYC) state_d = SPC_ST_RUN;
      SPC_ST_RUN: state_d = SPC_ST_RUN;
      default: state_d = SPC_ST_DOWN;
    endcase
    if (!pd_n_s) state_d = SPC_ST_DOWN;
  end
  assign capture = (state_q == SPC_ST_SETTLE) && (state_d == SPC_ST_RUN);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SPC_ST_DOWN;
      settle_q <= 4'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      settle_q <= (state_q == SPC_ST_SETTLE) ? settle_q + 4'h1 : 4'h0;
    end
  end

  // Straps latched once at startup and then held; a later pin change is ignored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lcc_q <= 1'b0;
      width_q <= 1'b0;
      double_q <= 1'b0;
      correct_q <= 1'b0;
      sync_enc_q <= 1'b0;
    end else if (clk_en && capture) begin
      lcc_q <= lcc_s;
      width_q <= lcc_s ? 1'b0 : width_s;
      double_q <= lcc_s ? 1'b0 : double_s;
      correct_q <= lcc_s ? 1'b0 : correct_s;
      sync_enc_q <= lcc_s ? 1'b0 : mode_s;
    end
  end

  // ************************************************************
  // General output mirror
  // ************************************************************
  // Small debounce delay keeps the mirror well inside the remote bound;
  // cleared on the same edge that leaves RUN so no high level leaks into power-down
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mirror_q <= 1'b0;
      mirror_cnt_q <= '0;
    end else if (clk_en) begin
      if (state_d != SPC_ST_RUN) begin
        mirror_q <= 1'b0;
        mirror_cnt_q <= '0;
      end else if (mirror_in_s == mirror_q) begin
        mirror_cnt_q <= '0;
      end else if (mirror_cnt_q == `SPC_MIRROR_DELAY_CYC) begin
        mirror_q <= mirror_in_s;
        mirror_cnt_q <= '0;
      end else begin
        mirror_cnt_q <= mirror_cnt_q + 1'b1;
      end
    end
  end
  assign remote_mirror_output = mirror_q;

  // ************************************************************
  // Decoded settings and pin functions
  // ************************************************************
  wire run = (state_q == SPC_ST_RUN);
  assign powered_down = !run;
  assign config_valid = run;
  assign ctrl_chan_active = run && lcc_q;
  assign bypass_mode = run && lcc_q && mode_s;
  assign strap_bus_wide = width_q;
  assign input_latch_width = width_q ? `SPC_LATCH_WIDE : `SPC_LATCH_NARROW;
  assign bit_times_per_pclk = width_q ? `SPC_BITS_PER_PCLK_WIDE : `SPC_BITS_PER_PCLK_NARROW;
  assign latency_limit_bits = spread_spectrum_en ? `SPC_LATENCY_SS_BITS : `SPC_LATENCY_NOSS_BITS;
  assign double_input_mode = double_q;
  assign error_correct_mode = correct_q ? `SPC_CORRECT_ON : `SPC_CORRECT_OFF;
  assign sync_encode_en = sync_enc_q;
  assign pins_14_15_are_sync = run && sync_enc_q;
  // Open-drain drive only in control-channel mode, low only
  assign bus_width_strap_o = 1'b0;
  assign bus_width_strap_oe_n = !(ctrl_chan_active && !general_port_1_out);
  assign shared_data_port_oe_n = ~({GPIO_W{ctrl_chan_active}} & shared_gpio_en & ~shared_gpio_out);
  // Mid level when neither threshold comparator fires
  assign cfg0_level = c0h_s ? SPC_LVL_HIGH : (c0l_s ? SPC_LVL_LOW : SPC_LVL_MID);
  assign cfg1_level = c1h_s ? SPC_LVL_HIGH : (c1l_s ? SPC_LVL_LOW : SPC_LVL_MID);

  // ************************************************************
  // Checks
  // ************************************************************
  property p_mirror_low_down;
    @(posedge sys_clk) disable iff (!rstn) !run |-> !remote_mirror_output;
  endproperty
  a_mirror_low_down: assert property (p_mirror_low_down) else $error("output high while down");
  // Window opens with an idle counter, so the third differing sample must be taken over
  property p_mirror;
    @(posedge sys_clk) disable iff (!rstn)
      ((state_d == SPC_ST_RUN) && clk_en && mirror_in_s != mirror_q && mirror_cnt_q == '0) ##1
      ((state_d == SPC_ST_RUN) && clk_en && mirror_in_s != mirror_q) [*2] |=>
      remote_mirror_output == $past(mirror_in_s);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror late");
  property p_down_follows_pin;
    @(posedge sys_clk) disable iff (!rstn) (clk_en && !pd_n_s) |=> powered_down;
  endproperty
  a_down_follows_pin: assert property (p_down_follows_pin) else $error("no power-down");
  property p_hold_straps;
    @(posedge sys_clk) disable iff (!rstn) (run && $past(run)) |->
      $stable(width_q) && $stable(sync_enc_q) && $stable(double_q) && $stable(correct_q);
  endproperty
  a_hold_straps: assert property (p_hold_straps) else $error("strap changed");
  property p_bit_times;
    @(posedge sys_clk) disable iff (!rstn)
      (input_latch_width == `SPC_LATCH_WIDE) == (bit_times_per_pclk == `SPC_BITS_PER_PCLK_WIDE);
  endproperty
  a_bit_times: assert property (p_bit_times) else $error("bad bit times");
  property p_od_only_ctrl;
    @(posedge sys_clk) disable iff (!rstn) !bus_width_strap_oe_n |-> ctrl_chan_active;
  endproperty
  a_od_only_ctrl: assert property (p_od_only_ctrl) else $error("drive in strap mode");
  property p_gpio_default;
    @(posedge sys_clk) disable iff (!rstn) (shared_gpio_en == '0) |-> (&shared_data_port_oe_n);
  endproperty
  a_gpio_default: assert property (p_gpio_default) else $error("data pin driven");
  property p_sync_pins;
    @(posedge sys_clk) disable iff (!rstn) pins_14_15_are_sync |-> (!lcc_q && run);
  endproperty
  a_sync_pins: assert property (p_sync_pins) else $error("sync in ctrl mode");
endmodule : spc_pin_config

// *** rtl/spc_pkg.sv ***
// Types for the serializer pin configuration block
package spc_pkg;
  typedef enum logic [1:0] {
    SPC_LVL_LOW,
    SPC_LVL_MID,
    SPC_LVL_HIGH
  } spc_level_e;
  typedef enum {
    SPC_ST_DOWN,
    SPC_ST_SETTLE,
    SPC_ST_RUN
  } spc_state_e;
endpackage : spc_pkg

// *** rtl/spc_sync.sv ***
// Two-flop synchroniser for one asynchronous pin
`timescale 1ns/100ps
module spc_sync
  import spc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic pin,
  spc_sync_if.src out
);
  logic meta_q;
  logic stable_q;

  // Only stable_q reads the first stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      stable_q <= 1'b0;
    end else if (clk_en) begin
      meta_q <= pin;
      stable_q <= meta_q;
    end
  end

  assign out.level = stable_q;
endmodule : spc_sync

// *** rtl/spc_sync_if.sv ***
// Interface carrying one synchronised pin between modules
`timescale 1ns/100ps
interface spc_sync_if;
  logic level;
  modport src (output level);
  modport dst (input level);
endinterface : spc_sync_if

// *** sim/spc_far_side.sv ***
// Far side model: board straps and three-level configuration drivers
`timescale 1ns/100ps
module spc_far_side
  import spc_pkg::*;
(
  input wire logic strap_level,
  input wire logic pin_oe_n,
  input wire logic [1:0] cfg0_sel,
  input wire logic [1:0] cfg1_sel,
  output logic bus_width_pin,
  output logic cfg0_hi,
  output logic cfg0_lo,
  output logic cfg1_hi,
  output logic cfg1_lo
);
  // Open drain: the device can only pull low, else the board level wins
  assign bus_width_pin = pin_oe_n ? strap_level : 1'b0;
  // Mid level is an open pin, so neither comparator trips
  assign cfg0_hi = (cfg0_sel == SPC_LVL_HIGH);
  assign cfg0_lo = (cfg0_sel == SPC_LVL_LOW);
  assign cfg1_hi = (cfg1_sel == SPC_LVL_HIGH);
  assign cfg1_lo = (cfg1_sel == SPC_LVL_LOW);
endmodule : spc_far_side

// *** sim/spc_pin_config_bench.sv ***
// Self-checking bench for the strap and control pin decoder
`timescale 1ns/100ps
module spc_pin_config_bench;
  import spc_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, pd_n = 1'b0, lcc = 1'b0, bw = 1'b0, mode_sel = 1'b0;
  logic dual_in = 1'b0, err_fix = 1'b0, rgi = 1'b0, gp1 = 1'b1, ss = 1'b0;
  logic [3:0] gen = 4'h0, gout = 4'h0, sd_oe_n;
  logic [1:0] lv0 = 2'h1, lv1 = 2'h1, ecm;
  logic bw_pin, c0h, c0l, c1h, c1l, bw_o, bw_oe_n, rmo, pdn_st, cca, byp, wide, dblm, sy, p1415, cv;
  logic [4:0] latch_w;
  logic [5:0] btp;
  logic [12:0] lat;
  spc_level_e l0, l1;
  int bad_count = 0, checks_done = 0, cycles = 0, v;
  // Core clock; the sensor's pixel clock range lies outside this model
  always #4 sys_clk = ~sys_clk;
  spc_far_side i_far (.strap_level(bw), .pin_oe_n(bw_oe_n), .cfg0_sel(lv0), .cfg1_sel(lv1),
    .bus_width_pin(bw_pin), .cfg0_hi(c0h), .cfg0_lo(c0l), .cfg1_hi(c1h), .cfg1_lo(c1l));
  spc_pin_config i_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .power_down_n(pd_n),
    .local_ctrl_chan_pin_en(lcc), .bus_width_strap_i(bw_pin), .bus_width_strap_o(bw_o),
    .bus_width_strap_oe_n(bw_oe_n), .ctrl_mode_select(mode_sel), .double_input_strap(dual_in),
    .error_correct_strap(err_fix), .tri_level_cfg_0_hi(c0h), .tri_level_cfg_0_lo(c0l),
    .tri_level_cfg_1_hi(c1h), .tri_level_cfg_1_lo(c1l), .remote_general_input(rgi),
    .general_port_1_out(gp1), .shared_gpio_en(gen), .shared_gpio_out(gout),
    .spread_spectrum_en(ss), .shared_data_port_oe_n(sd_oe_n), .remote_mirror_output(rmo),
    .powered_down(pdn_st), .ctrl_chan_active(cca), .bypass_mode(byp), .strap_bus_wide(wide),
    .input_latch_width(latch_w), .double_input_mode(dblm), .error_correct_mode(ecm),
    .sync_encode_en(sy), .pins_14_15_are_sync(p1415), .bit_times_per_pclk(btp),
    .latency_limit_bits(lat), .cfg0_level(l0), .cfg1_level(l1), .config_valid(cv));
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Inputs always move 1 ns after the edge so sampling never races
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic power_up();
    int i;
    pd_n = 1'b0;
    tick(4);
    chk(pdn_st, 1'h1);
    chk(rmo, 1'h0);
    pd_n = 1'b1;
    for (i = 0; i < 20 && cv !== 1'b1; i++) tick(1);
    chk(cv, 1'h1);
    chk(pdn_st, 1'h0);
  endtask : power_up
  task automatic mirror(input logic m);
    int i;
    rgi = m;
    for (i = 0; i < 12 && rmo !== m; i++) tick(1);
    chk(rmo, m);
  endtask : mirror
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // Hang guard, far above the fewer than a hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    tick(3);
    rstn = 1'b1;
    // Strap mode, every strap low then high, then width, sync and double straps held against changes
    for (v = 0; v < 2; v++) begin
      {bw, mode_sel, dual_in, err_fix, ss} = {5{v[0]}};
      power_up();
      chk(cca, 1'h0);
      chk(bw_oe_n, 1'h1);
      chk(latch_w, v ? 5'h1E : 5'h16);
      chk(btp, v ? 6'h28 : 6'h1E);
      chk({sy, p1415}, v ? 2'h3 : 2'h0);
      chk(dblm, v[0]);
      chk(ecm, v ? 2'h2 : 2'h0);
      chk(lat, v ? 13'h1AE0 : 13'h0BE0);
      {bw, mode_sel, dual_in, err_fix} = {4{~v[0]}};
      tick(6);
      chk({wide, sy, dblm}, v ? 3'h7 : 3'h0);
    end
    // Control-channel mode: open-drain port, mode pin, shared ports
    lcc = 1'b1;
    gp1 = 1'b0;
    power_up();
    chk({cca, byp, wide, sy}, 4'h8);
    chk({bw_oe_n, bw_o}, 2'h0);
    gp1 = 1'b1;
    mode_sel = 1'b1;
    tick(4);
    chk({bw_oe_n, byp}, 2'h3);
    chk(sd_oe_n, 4'hF);
    gen = 4'hF;
    gout = 4'h5;
    tick(1);
    chk(sd_oe_n, 4'h5);
    // Three-level inputs, both pins stepped through all three levels in opposite order
    for (v = 0; v < 3; v++) begin
      lv0 = v[1:0];
      lv1 = 2'h2 - v[1:0];
      tick(4);
      chk(l0, lv0);
      chk(l1, lv1);
    end
    mirror(1'b1);
    mirror(1'b0);
    mirror(1'b1);
    pd_n = 1'b0;
    tick(4);
    chk({rmo, pdn_st}, 2'h1);
    conclude();
  end
endmodule : spc_pin_config_bench
